// >>> inc/dar_defines.vh
/*
 constants for the dual converter serial readout: frame layout, code width, fifo size.
 assumes inclusion by bare name from the design files.
*/
`ifndef DAR_DEFINES_VH
`define DAR_DEFINES_VH
`define DAR_CODE_BITS 14
`define DAR_LEAD_ZEROS 2
`define DAR_SHORT_FRAME 16
`define DAR_LONG_FRAME 18
`define DAR_DUAL_FRAME 36
`define DAR_CNT_BITS 6
`define DAR_FIFO_DEPTH 16
`define DAR_FIFO_AW 4
`define DAR_SAMPLE_WIDTH 28
`endif

// >>> core/dar_fifo.v
/*
 parameterised flip-flop fifo with valid and ready on both sides.
 assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/10ps
module dar_fifo #(
  parameter WIDTH = 28,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clk,
  input wire resetn,
  input wire [WIDTH-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output reg [WIDTH-1:0] out_data,
  output wire out_valid,
  input wire out_ready
);
  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0] wr_reg;
  reg [AW-1:0] rd_reg;
  reg [AW:0] count_reg;
  wire push;
  wire pop;
  integer i;

  assign in_ready = (count_reg != DEPTH[AW:0]);
  assign out_valid = (count_reg != {(AW+1){1'b0}});
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always @* begin
    out_data = mem_reg[rd_reg];
  end

  always @(posedge clk) begin
    if (!resetn) begin
      wr_reg <= {AW{1'b0}};
      rd_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem_reg[i] <= {WIDTH{1'b0}};
      end
    end else begin
      if (push) begin
        mem_reg[wr_reg] <= in_data;
        wr_reg <= wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= rd_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule // dar_fifo

// >>> core/dar_readout.v
/*
 serial readout of a dual simultaneous-sampling 14-bit converter, on the device side.
 assumes the host drives the chip select and serial clock pins asynchronously; both are
 synchronised to CORE_CLK, which must run well above four times the serial clock.
 converted pairs arrive from the converter core through a fifo; the pair at its head is
 captured at the falling select edge.
 a frame cut before the sixteenth serial fall gives no conversion-done pulse, and the
 sampler then returns to tracking only when select goes high.
*/
`timescale 1ns/10ps
`include "dar_defines.vh"
module dar_readout #(
  parameter CODE_BITS = `DAR_CODE_BITS,
  parameter FIFO_DEPTH = `DAR_FIFO_DEPTH
) (
  input wire CORE_CLK,
  input wire RESETN,
  input wire CHIP_SELECT_N,
  input wire SERIAL_CLK,
  input wire [CODE_BITS-1:0] CH1_CODE,
  input wire [CODE_BITS-1:0] CH2_CODE,
  input wire CODE_VALID,
  output wire CODE_READY,
  output reg CHANNEL_ONE_SERIAL_OUT,
  output reg CHANNEL_ONE_SERIAL_OE,
  output reg CHANNEL_TWO_SERIAL_OUT,
  output reg CHANNEL_TWO_SERIAL_OE,
  output reg TRACKING,
  output reg CONVERT_DONE
);
  localparam ST_IDLE = 3'h1;
  localparam ST_CONV = 3'h2;
  localparam ST_TAIL = 3'h4;
  // frame positions at counter width, so compares and subtractions stay one width
  localparam [`DAR_CNT_BITS-1:0] LONG_IDX = `DAR_LONG_FRAME;
  localparam [`DAR_CNT_BITS-1:0] LAST_CONV_IDX = `DAR_SHORT_FRAME - 1;
  localparam [`DAR_CNT_BITS-1:0] DUAL_IDX = `DAR_DUAL_FRAME;

  reg [2:0] cs_sync_reg;
  reg [2:0] sclk_sync_reg;
  wire cs_fall;
  wire cs_high;
  wire sclk_fall;
  wire [`DAR_SAMPLE_WIDTH-1:0] head_data;
  wire head_valid;
  reg [CODE_BITS-1:0] held1_reg;
  reg [CODE_BITS-1:0] held2_reg;
  reg [`DAR_CNT_BITS-1:0] edge_reg;
  reg [2:0] state_reg;
  reg [2:0] state_next;
  // next bit index and the end-of-conversion strobe, each used in more than one place
  wire [`DAR_CNT_BITS-1:0] next_idx;
  wire conv_end;
  wire [CODE_BITS-1:0] head1;
  wire [CODE_BITS-1:0] head2;

  // bit sent at a given edge index; zeros pad the frame, code goes msb first
  function bit_at;
    input [`DAR_CNT_BITS-1:0] idx;
    input [CODE_BITS-1:0] own;
    input [CODE_BITS-1:0] other;
    reg [`DAR_CNT_BITS-1:0] pos;
    begin
      pos = (idx >= LONG_IDX) ? idx - LONG_IDX : idx;
      if (pos < `DAR_LEAD_ZEROS || pos >= `DAR_SHORT_FRAME) begin
        bit_at = 1'b0;
      end else if (idx >= `DAR_LONG_FRAME) begin
        bit_at = other[`DAR_SHORT_FRAME-1-pos];
      end else begin
        bit_at = own[`DAR_SHORT_FRAME-1-pos];
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; only the second and third stages are read
  always @(posedge CORE_CLK) begin
    if (!RESETN) begin
      cs_sync_reg <= 3'h7;
      sclk_sync_reg <= 3'h7;
    end else begin
      cs_sync_reg <= {cs_sync_reg[1:0], CHIP_SELECT_N};
      sclk_sync_reg <= {sclk_sync_reg[1:0], SERIAL_CLK};
    end
  end
  assign cs_fall = cs_sync_reg[2] & ~cs_sync_reg[1];
  assign cs_high = cs_sync_reg[1];
  assign sclk_fall = sclk_sync_reg[2] & ~sclk_sync_reg[1] & ~cs_high;

  ////////////////////////////////////////////////////////////////////////////
  // converted pairs wait here; a stalled core sees CODE_READY low
  dar_fifo #(
    .WIDTH(`DAR_SAMPLE_WIDTH),
    .DEPTH(FIFO_DEPTH),
    .AW(`DAR_FIFO_AW)
  ) u_fifo (
    .clk(CORE_CLK),
    .resetn(RESETN),
    .in_data({CH1_CODE, CH2_CODE}),
    .in_valid(CODE_VALID),
    .in_ready(CODE_READY),
    .out_data(head_data),
    .out_valid(head_valid),
    .out_ready(cs_fall)
  );

  ////////////////////////////////////////////////////////////////////////////
  // frame state: conversion runs from the select fall to the sixteenth serial fall
  assign next_idx = edge_reg + 1'b1;
  assign conv_end = sclk_fall & (state_reg == ST_CONV) & (edge_reg == LAST_CONV_IDX);
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (cs_fall) begin
          state_next = ST_CONV;
        end
      end
      ST_CONV: begin
        if (cs_high) begin
          state_next = ST_IDLE;
        end else if (conv_end) begin
          state_next = ST_TAIL;
        end
      end
      ST_TAIL: begin
        if (cs_high) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always @(posedge CORE_CLK) begin
    if (!RESETN) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // falling-edge counter; it saturates, so edges past the dual frame keep shifting zeros
  always @(posedge CORE_CLK) begin
    if (!RESETN) begin
      edge_reg <= {`DAR_CNT_BITS{1'b0}};
    end else if (cs_fall || cs_high) begin
      edge_reg <= {`DAR_CNT_BITS{1'b0}};
    end else if (sclk_fall && edge_reg < DUAL_IDX) begin
      edge_reg <= next_idx;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // an empty fifo at the select fall yields a zero pair rather than stale data
  assign head1 = head_valid ? head_data[`DAR_SAMPLE_WIDTH-1:CODE_BITS] : {CODE_BITS{1'b0}};
  assign head2 = head_valid ? head_data[CODE_BITS-1:0] : {CODE_BITS{1'b0}};
  always @(posedge CORE_CLK) begin
    if (!RESETN) begin
      held1_reg <= {CODE_BITS{1'b0}};
      held2_reg <= {CODE_BITS{1'b0}};
    end else if (cs_fall) begin
      held1_reg <= head1;
      held2_reg <= head2;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // data lines: a new bit after each serial fall; zero, and released, outside a frame
  always @(posedge CORE_CLK) begin
    if (!RESETN) begin
      CHANNEL_ONE_SERIAL_OUT <= 1'b0;
      CHANNEL_TWO_SERIAL_OUT <= 1'b0;
      CHANNEL_ONE_SERIAL_OE <= 1'b0;
      CHANNEL_TWO_SERIAL_OE <= 1'b0;
    end else begin
      CHANNEL_ONE_SERIAL_OE <= ~cs_high;
      CHANNEL_TWO_SERIAL_OE <= ~cs_high;
      if (cs_fall || cs_high) begin
        // the first leading zero stands before any serial fall
        CHANNEL_ONE_SERIAL_OUT <= 1'b0;
        CHANNEL_TWO_SERIAL_OUT <= 1'b0;
      end else if (sclk_fall) begin
        CHANNEL_ONE_SERIAL_OUT <= bit_at(next_idx, held1_reg, held2_reg);
        CHANNEL_TWO_SERIAL_OUT <= bit_at(next_idx, held2_reg, held1_reg);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sampler status; tracking resumes at the last conversion edge, or at select high if the frame is cut before it
  always @(posedge CORE_CLK) begin
    if (!RESETN) begin
      TRACKING <= 1'b1;
      CONVERT_DONE <= 1'b0;
    end else begin
      CONVERT_DONE <= conv_end;
      if (cs_fall) begin
        TRACKING <= 1'b0;
      end else if (cs_high || conv_end) begin
        TRACKING <= 1'b1;
      end
    end
  end
endmodule // dar_readout

// >>> verification/dar_readout_assertions.sv
/* pin checker for dar_readout.
 assumes a bind onto dar_readout and one CORE_CLK domain. */
`timescale 1ns/10ps
module dar_readout_assertions (
  input wire CORE_CLK,
  input wire RESETN,
  input wire CHIP_SELECT_N,
  input wire SERIAL_CLK,
  input wire CHANNEL_ONE_SERIAL_OUT,
  input wire CHANNEL_ONE_SERIAL_OE,
  input wire CHANNEL_TWO_SERIAL_OUT,
  input wire CHANNEL_TWO_SERIAL_OE,
  input wire TRACKING,
  input wire CONVERT_DONE
);
  wire e1 = CHANNEL_ONE_SERIAL_OE;
  wire d1 = CHANNEL_ONE_SERIAL_OUT;
  wire d2 = CHANNEL_TWO_SERIAL_OUT;
  // window of five edges covers the two sync stages plus the output register
  reg [5:0] hist_reg;
  wire fell_recent = |(~hist_reg[4:0] & hist_reg[5:1]);
  always @(posedge CORE_CLK) hist_reg <= {hist_reg[4:0], SERIAL_CLK};
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);
  property p_pair; e1 == CHANNEL_TWO_SERIAL_OE; endproperty
  a_pair: assert property (p_pair) else $error("enables differ");
  property p_float; !e1 |-> !d1 && !d2; endproperty
  a_float: assert property (p_float) else $error("line driven while idle");
  property p_open; $fell(CHIP_SELECT_N) |-> ##[2:4] e1; endproperty
  a_open: assert property (p_open) else $error("frame did not open");
  property p_close; $rose(CHIP_SELECT_N) |-> ##[2:4] !e1; endproperty
  a_close: assert property (p_close) else $error("line not released");
  property p_shift; e1 && $past(e1) && (d1 != $past(d1) || d2 != $past(d2)) |-> fell_recent;
  endproperty
  a_shift: assert property (p_shift) else $error("bit moved without falling edge");
  property p_done; CONVERT_DONE |-> fell_recent && e1 ##1 !CONVERT_DONE; endproperty
  a_done: assert property (p_done) else $error("done without serial edge");
  property p_hold; $rose(e1) |-> ##[0:1] !TRACKING; endproperty
  a_hold: assert property (p_hold) else $error("sampler still tracking");
  property p_track; CONVERT_DONE |-> ##[0:1] TRACKING; endproperty
  a_track: assert property (p_track) else $error("no return to tracking");
endmodule // dar_readout_assertions

// >>> verification/dar_host_model.sv
/* host serial controller: drives select and serial clock, reads both lines.
 assumes no phase relation to the core clock. */
`timescale 1ns/10ps
module dar_host_model (
  output reg CHIP_SELECT_N,
  output reg SERIAL_CLK,
  input wire CHANNEL_ONE_SERIAL_OUT,
  input wire CHANNEL_ONE_SERIAL_OE,
  input wire CHANNEL_TWO_SERIAL_OUT,
  input wire CHANNEL_TWO_SERIAL_OE
);
  initial begin
    CHIP_SELECT_N = 1'b1;
    SERIAL_CLK = 1'b1;
  end
  // clock stands high between frames; a released line reads unknown so it never matches
  task frame(input integer n, input integer half, output [35:0] a, output [35:0] b);
    integer i;
    begin
      a = 36'h0;
      b = 36'h0;
      #3.3 CHIP_SELECT_N = 1'b0;
      for (i = 0; i < n; i = i + 1) begin
        #half;
        a = {a[34:0], CHANNEL_ONE_SERIAL_OE ? CHANNEL_ONE_SERIAL_OUT : 1'hX};
        b = {b[34:0], CHANNEL_TWO_SERIAL_OE ? CHANNEL_TWO_SERIAL_OUT : 1'hX};
        SERIAL_CLK = 1'b0;
        #half SERIAL_CLK = 1'b1;
      end
      #half CHIP_SELECT_N = 1'b1;
      #40;
    end
  endtask
endmodule // dar_host_model

// >>> verification/dar_readout_tb.sv
/* bench for dar_readout: fills the fifo, then reads frames of 16, 18 and 36 clocks.
 assumes dar_host_model and the bound checker. */
`timescale 1ns/10ps
module dar_readout_tb;
  reg CORE_CLK, RESETN, CODE_VALID;
  reg [13:0] CH1_CODE, CH2_CODE;
  wire CHIP_SELECT_N, SERIAL_CLK, CODE_READY, TRACKING, CONVERT_DONE;
  wire CHANNEL_ONE_SERIAL_OUT, CHANNEL_ONE_SERIAL_OE;
  wire CHANNEL_TWO_SERIAL_OUT, CHANNEL_TWO_SERIAL_OE;
  integer n_fail = 0, n_checks = 0, k, n;
  integer n_done = 0;
  reg [15:0] seed = 16'h000D;
  reg [27:0] q [0:16];
  reg [35:0] sa, sb;
  dar_readout u_dut (.CORE_CLK, .RESETN, .CHIP_SELECT_N, .SERIAL_CLK, .CH1_CODE, .CH2_CODE,
    .CODE_VALID, .CODE_READY, .CHANNEL_ONE_SERIAL_OUT, .CHANNEL_ONE_SERIAL_OE,
    .CHANNEL_TWO_SERIAL_OUT, .CHANNEL_TWO_SERIAL_OE, .TRACKING, .CONVERT_DONE);
  dar_host_model u_host (.CHIP_SELECT_N, .SERIAL_CLK, .CHANNEL_ONE_SERIAL_OUT,
    .CHANNEL_ONE_SERIAL_OE, .CHANNEL_TWO_SERIAL_OUT, .CHANNEL_TWO_SERIAL_OE);
  initial begin
    CORE_CLK = 1'b0;
    forever #2 CORE_CLK = ~CORE_CLK;
  end
  // conversion-done pulses seen so far; every frame here reaches the sixteenth fall
  always @(posedge CORE_CLK) begin
    if (CONVERT_DONE === 1'b1) begin
      n_done <= n_done + 1;
    end
  end
  function [15:0] lfsr(input [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function [35:0] frame_bits(input integer n, input [13:0] own, input [13:0] oth);
    frame_bits = {2'h0, own, 4'h0, oth, 2'h0} >> (36 - n);
  endfunction
  task check(input [47:0] what, input [35:0] seen, input [35:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("ERROR %0s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  // valid stays up between pushes so it is never written twice in one step
  task push(input [13:0] a, input [13:0] b);
    begin
      CH1_CODE = a;
      CH2_CODE = b;
      CODE_VALID = 1'b1;
      @(posedge CORE_CLK);
      #1;
    end
  endtask
  task final_report;
    begin
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
        $display("verification passed");
      end else begin
        $display("verification failed");
      end
      $finish;
    end
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    RESETN = 1'b0;
    CODE_VALID = 1'b0;
    CH1_CODE = 14'h0000;
    CH2_CODE = 14'h0000;
    repeat (2) @(posedge CORE_CLK);
    #1 RESETN = 1'b1;
    repeat (3) @(posedge CORE_CLK);
    #1;
    for (k = 0; k < 16; k = k + 1) begin
      seed = lfsr(lfsr(seed));
      q[k] = (k == 0) ? {14'h3FFF, 14'h0000} : (k == 1) ? {14'h2000, 14'h1FFF} : {seed, 12'h5A3};
      check("ready", CODE_READY, 36'h1);
      push(q[k][27:14], q[k][13:0]);
    end
    check("full", CODE_READY, 36'h0);
    push(14'h1555, 14'h2AAA);
    CODE_VALID = 1'b0;
    q[16] = 28'h0000000;
    for (k = 0; k < 17; k = k + 1) begin
      n = (k % 3 == 0) ? 16 : (k % 3 == 1) ? 18 : 36;
      u_host.frame(n, 32, sa, sb);
      check("ch_one", sa, frame_bits(n, q[k][27:14], q[k][13:0]));
      check("ch_two", sb, frame_bits(n, q[k][13:0], q[k][27:14]));
      check("track", TRACKING, 36'h1);
      check("done", n_done, k + 1);
      $display("frame %0d of %0d clocks done", k, n);
    end
    final_report;
  end
  initial begin
    #200000;
    n_fail = n_fail + 1;
    final_report;
  end
endmodule // dar_readout_tb
bind dar_readout dar_readout_assertions u_chk (.CORE_CLK, .RESETN, .CHIP_SELECT_N, .SERIAL_CLK,
  .CHANNEL_ONE_SERIAL_OUT, .CHANNEL_ONE_SERIAL_OE, .CHANNEL_TWO_SERIAL_OUT,
  .CHANNEL_TWO_SERIAL_OE, .TRACKING, .CONVERT_DONE);
